// File: logic/fpp_pin_logic.sv
// flash multi-purpose pin logic: status protection, quad switch, pause and reset
// assumes AHB-Lite register access and a core that shifts on sck_rise_o
`default_nettype none

module fpp_pin_logic #(
	parameter bit HAS_DED_RST = 1'b1
) (
	// clock, reset, enable
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	// flash pins
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic        ded_rst_n_i,
	input  wire logic        io2_i,
	output logic             io2_o,
	output logic             io2_oen_o,
	input  wire logic        io3_i,
	output logic             io3_o,
	output logic             io3_oen_o,
	output logic             so_o,
	output logic             so_oen_o,
	// core side
	input  wire logic        so_dout_i,
	input  wire logic        so_drive_i,
	input  wire logic [1:0]  quad_dout_i,
	input  wire logic        quad_drive_i,
	output logic             sck_rise_o,
	output logic             pause_o,
	output logic             dev_reset_o,
	output logic             quad_mode_o,
	output logic [1:0]       quad_din_o
);

	// synchronisers
	fpp_pkg::fpp_pins_s s1_r, s1_nxt, s2_r, s2_nxt, pins_in;
	logic               sck_prev_r, sck_prev_nxt;

	// registers and bus state
	fpp_pkg::fpp_status_s stat_r, stat_nxt;
	logic                 deddis_r, deddis_nxt;
	logic                 pfs_r, pfs_nxt;
	logic                 wr_pend_r, wr_pend_nxt;
	logic [7:0]           addr_r, addr_nxt;
	logic [31:0]          hrdata_r, hrdata_nxt;

	// pin and core outputs
	logic       so_r, so_nxt, so_oen_r, so_oen_nxt;
	logic       io2_r, io2_nxt, io2_oen_r, io2_oen_nxt;
	logic       io3_r, io3_nxt, io3_oen_r, io3_oen_nxt;
	logic       rise_r, rise_nxt, pause_r, pause_nxt, rst_r, rst_nxt;
	logic [1:0] qdin_r, qdin_nxt;

	// derived functions
	logic shared_rst_fn, pause_fn, pause_act, ded_rst_act, reset_act, prot_locked;
	logic wr_stat, addr_ph;
	fpp_pkg::fpp_status_s wr_val;

	assign pins_in = '{cs_n: cs_n_i, wp: io2_i, io3: io3_i, ded_rst_n: ded_rst_n_i, sck: sck_i};

	always_comb begin
		s1_nxt       = s1_r;
		s2_nxt       = s2_r;
		sck_prev_nxt = sck_prev_r;
		if (ce_i) begin
			s1_nxt       = pins_in;
			s2_nxt       = s1_r;
			sck_prev_nxt = s2_r.sck;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_r       <= '{cs_n: 1'b1, wp: 1'b1, io3: 1'b1, ded_rst_n: 1'b1, sck: 1'b0};
			s2_r       <= '{cs_n: 1'b1, wp: 1'b1, io3: 1'b1, ded_rst_n: 1'b1, sck: 1'b0};
			sck_prev_r <= 1'b0;
		end else begin
			s1_r       <= s1_nxt;
			s2_r       <= s2_nxt;
			sck_prev_r <= sck_prev_nxt;
		end
	end

	// shared pin function; quad mode removes both pause and shared reset
	always_comb begin
		if (HAS_DED_RST)
			shared_rst_fn = !stat_r.quad_enable && deddis_r && pfs_r;
		else
			shared_rst_fn = !stat_r.quad_enable && pfs_r;
		pause_fn    = !stat_r.quad_enable && !shared_rst_fn;
		pause_act   = pause_fn && !s2_r.io3 && !s2_r.cs_n;
		ded_rst_act = HAS_DED_RST && !deddis_r && !s2_r.ded_rst_n;
		reset_act   = ded_rst_act || (shared_rst_fn && !s2_r.io3);
		// write protect only counts while the pin is not io2
		prot_locked = stat_r.status_write_disable && !s2_r.wp && !stat_r.quad_enable;
	end

	// bus and registers
	assign addr_ph = hsel_i && htrans_i[1] && hready_i;
	assign wr_stat = ce_i && wr_pend_r && (addr_r == fpp_pkg::ADDR_STATUS);
	assign wr_val  = '{status_write_disable: hwdata_i[fpp_pkg::STAT_SWD_BIT],
	                   quad_enable: hwdata_i[fpp_pkg::STAT_QE_BIT],
	                   prot_level: hwdata_i[fpp_pkg::STAT_PROT_MSB:fpp_pkg::STAT_PROT_LSB]};

	always_comb begin
		stat_nxt    = stat_r;
		deddis_nxt  = deddis_r;
		pfs_nxt     = pfs_r;
		wr_pend_nxt = wr_pend_r;
		addr_nxt    = addr_r;
		hrdata_nxt  = hrdata_r;
		if (ce_i) begin
			wr_pend_nxt = addr_ph && hwrite_i;
			addr_nxt    = haddr_i[7:0];
			if (wr_pend_r) begin
				// a locked write changes nothing at all
				if (addr_r == fpp_pkg::ADDR_STATUS && !prot_locked)
					stat_nxt = wr_val;
				if (addr_r == fpp_pkg::ADDR_FUNC)
					deddis_nxt = hwdata_i[fpp_pkg::FUNC_DEDDIS_BIT];
				if (addr_r == fpp_pkg::ADDR_READP)
					pfs_nxt = hwdata_i[fpp_pkg::READP_PFS_BIT];
			end
			// status, func and readp read data built from next values so a write just before is seen
			hrdata_nxt = 32'h0000_0000;
			if (addr_ph && !hwrite_i) begin
				unique case (haddr_i[7:0])
					fpp_pkg::ADDR_STATUS: begin
						hrdata_nxt[fpp_pkg::STAT_SWD_BIT] = stat_nxt.status_write_disable;
						hrdata_nxt[fpp_pkg::STAT_QE_BIT]  = stat_nxt.quad_enable;
						hrdata_nxt[fpp_pkg::STAT_PROT_MSB:fpp_pkg::STAT_PROT_LSB] = stat_nxt.prot_level;
					end
					fpp_pkg::ADDR_FUNC:  hrdata_nxt[fpp_pkg::FUNC_DEDDIS_BIT] = deddis_nxt;
					fpp_pkg::ADDR_READP: hrdata_nxt[fpp_pkg::READP_PFS_BIT]   = pfs_nxt;
					fpp_pkg::ADDR_PINS:  hrdata_nxt[8:0] = {shared_rst_fn, HAS_DED_RST, reset_act, pause_act,
					                                        prot_locked, s2_r.cs_n, s2_r.ded_rst_n, s2_r.io3,
					                                        s2_r.wp};
					default: hrdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_r    <= fpp_pkg::STATUS_RST;
			deddis_r  <= fpp_pkg::DEDDIS_RST;
			pfs_r     <= fpp_pkg::PFS_RST;
			wr_pend_r <= 1'b0;
			addr_r    <= 8'h00;
			hrdata_r  <= 32'h0000_0000;
		end else begin
			stat_r    <= stat_nxt;
			deddis_r  <= deddis_nxt;
			pfs_r     <= pfs_nxt;
			wr_pend_r <= wr_pend_nxt;
			addr_r    <= addr_nxt;
			hrdata_r  <= hrdata_nxt;
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o     = fpp_pkg::HRESP_OKAY;
	assign hrdata_o    = hrdata_r;

	// pin drive; enables are active low
	always_comb begin
		so_nxt      = so_r;
		so_oen_nxt  = so_oen_r;
		io2_nxt     = io2_r;
		io2_oen_nxt = io2_oen_r;
		io3_nxt     = io3_r;
		io3_oen_nxt = io3_oen_r;
		rise_nxt    = rise_r;
		pause_nxt   = pause_r;
		rst_nxt     = rst_r;
		qdin_nxt    = qdin_r;
		if (ce_i) begin
			so_nxt      = so_dout_i;
			so_oen_nxt  = !(so_drive_i && !s2_r.cs_n && !pause_act && !reset_act);
			io2_nxt     = quad_dout_i[0];
			io2_oen_nxt = !(stat_r.quad_enable && quad_drive_i && !s2_r.cs_n && !reset_act);
			io3_nxt     = quad_dout_i[1];
			io3_oen_nxt = !(stat_r.quad_enable && quad_drive_i && !s2_r.cs_n && !reset_act);
			// sck edges are swallowed while paused, so the shift state is kept
			rise_nxt    = s2_r.sck && !sck_prev_r && !s2_r.cs_n && !pause_act && !reset_act;
			pause_nxt   = pause_act;
			rst_nxt     = reset_act;
			qdin_nxt    = stat_r.quad_enable ? {s2_r.io3, s2_r.wp} : 2'b00;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			so_r      <= 1'b0;
			so_oen_r  <= 1'b1;
			io2_r     <= 1'b0;
			io2_oen_r <= 1'b1;
			io3_r     <= 1'b0;
			io3_oen_r <= 1'b1;
			rise_r    <= 1'b0;
			pause_r   <= 1'b0;
			rst_r     <= 1'b0;
			qdin_r    <= 2'b00;
		end else begin
			so_r      <= so_nxt;
			so_oen_r  <= so_oen_nxt;
			io2_r     <= io2_nxt;
			io2_oen_r <= io2_oen_nxt;
			io3_r     <= io3_nxt;
			io3_oen_r <= io3_oen_nxt;
			rise_r    <= rise_nxt;
			pause_r   <= pause_nxt;
			rst_r     <= rst_nxt;
			qdin_r    <= qdin_nxt;
		end
	end

	assign so_o        = so_r;
	assign so_oen_o    = so_oen_r;
	assign io2_o       = io2_r;
	assign io2_oen_o   = io2_oen_r;
	assign io3_o       = io3_r;
	assign io3_oen_o   = io3_oen_r;
	assign sck_rise_o  = rise_r;
	assign pause_o     = pause_r;
	assign dev_reset_o = rst_r;
	assign quad_mode_o = stat_r.quad_enable;
	assign quad_din_o  = qdin_r;

	// checks
	a_locked_write_kept: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_stat && prot_locked) |=> (stat_r == $past(stat_r)))
		else $error("locked status bits changed");

	a_open_write_taken: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_stat && !prot_locked) |=> (stat_r == $past(wr_val)))
		else $error("unlocked status write not stored");

	a_swd_clear_open: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_stat && !stat_r.status_write_disable) |=> (stat_r == $past(wr_val)))
		else $error("status write refused with write disable clear");

	a_quad_no_protect: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_stat && stat_r.quad_enable) |=> (stat_r == $past(wr_val)))
		else $error("status write refused in quad mode");

	a_quad_no_pause: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && stat_r.quad_enable) |=> (!pause_o && ($past(ded_rst_act) || !dev_reset_o)))
		else $error("pause or shared reset active in quad mode");

	a_select_no_ded: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && !HAS_DED_RST && !stat_r.quad_enable && pfs_r && !s2_r.io3) |=> (dev_reset_o && !pause_o))
		else $error("shared pin not reset with select bit set");

	a_ded_forces_pause: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && HAS_DED_RST && !stat_r.quad_enable && !deddis_r && !s2_r.io3 && !s2_r.cs_n) |=> pause_o)
		else $error("shared pin not pause with dedicated reset on");

	a_ded_off_select: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && HAS_DED_RST && !stat_r.quad_enable && deddis_r && pfs_r && !s2_r.io3) |=> (dev_reset_o && !pause_o))
		else $error("shared pin ignores select bit");

	a_pause_no_shift: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && pause_act) |=> (!sck_rise_o && pause_o))
		else $error("clock edge passed while paused");

	a_pause_so_float: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && pause_act && !s2_r.cs_n) |=> so_oen_o)
		else $error("serial output driven while paused");

	a_reset_float: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && reset_act) |=> (so_oen_o && io2_oen_o && io3_oen_o && dev_reset_o))
		else $error("outputs driven during reset");

	a_ded_disabled: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(ce_i && deddis_r && !shared_rst_fn) |=> !dev_reset_o)
		else $error("dedicated reset acts while disabled");

endmodule // fpp_pin_logic

`default_nettype wire

// File: logic/fpp_pkg.sv
// package for the serial flash pin-function and protection block
// assumes a single AHB-Lite master and one serial flash pin set
`default_nettype none

package fpp_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FUNC   = 8'h04;
	localparam logic [7:0] ADDR_READP  = 8'h08;
	localparam logic [7:0] ADDR_PINS   = 8'h0c;

	// field positions
	localparam int STAT_SWD_BIT     = 7;
	localparam int STAT_QE_BIT      = 6;
	localparam int STAT_PROT_MSB    = 5;
	localparam int STAT_PROT_LSB    = 2;
	localparam int FUNC_DEDDIS_BIT  = 0;
	localparam int READP_PFS_BIT    = 7;

	// reset values
	localparam logic [5:0] STATUS_RST = 6'h00;
	localparam logic       DEDDIS_RST = 1'b0;
	localparam logic       PFS_RST    = 1'b0;

	// bus encodings
	localparam logic       HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic       status_write_disable;
		logic       quad_enable;
		logic [3:0] prot_level;
	} fpp_status_s;

	typedef struct packed {
		logic cs_n;
		logic wp;
		logic io3;
		logic ded_rst_n;
		logic sck;
	} fpp_pins_s;

endpackage

`default_nettype wire

// File: verif/fpp_spi_host.sv
// spi host model: drives chip select and a mode 0 serial clock
// assumes the bench raises run_i for a frame; sck stands at 0 outside frames
`default_nettype none

module fpp_spi_host (
	// frame request
	input  wire logic run_i,
	// pins towards the flash
	output logic      cs_n_o,
	output logic      sck_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// 320 ns link clock, fixed phase against the system clock
	// never pulses the reset pins itself, so no internal write is cut short
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		forever begin
			wait (run_i);
			// keep every pin edge clear of the system clock edges
			#5;
			cs_n_o = 1'b0;
			#170;
			while (run_i) begin
				sck_o = 1'b1;
				#160;
				sck_o = 1'b0;
				#160;
			end
			#160;
			cs_n_o = 1'b1;
		end
	end
endmodule // fpp_spi_host

`default_nettype wire

// File: verif/tb_fpp_pin_logic.sv
// self-checking bench for the flash pin-function and protection block
// assumes zero-wait ahb-lite slave and registered pin outputs (3 edges)
`default_nettype none

module tb_fpp_pin_logic;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys_i = 0, arst_n_i = 0, run = 0, hwrite = 0, so_d = 1, so_dr = 1;
	logic        wp_lvl = 0, hold_lvl = 1, ded_lvl = 1;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic        hready, hresp, so_oen, pause, dev_rst, quad, io2_o, io2_oen, io3_o, io3_oen;
	logic        cs_n, sck, rise, so_q, pause_b, dev_rst_b, qdr = 0;
	logic [1:0]  qdin, qd = 0;
	wire logic   io2_w, io3_w;
	int          errors = 0, n_checks = 0, n_rise = 0, n0;

	// host lines are pulled to the host's level whenever the flash floats them
	assign io2_w = io2_oen ? wp_lvl : io2_o;
	assign io3_w = io3_oen ? hold_lvl : io3_o;

	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (rise) n_rise <= n_rise + 1;

	fpp_spi_host i_fpp_spi_host (.run_i(run), .cs_n_o(cs_n), .sck_o(sck));

	fpp_pin_logic i_fpp_pin_logic (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
		.cs_n_i(cs_n), .sck_i(sck), .ded_rst_n_i(ded_lvl), .io2_i(io2_w), .io2_o(io2_o),
		.io2_oen_o(io2_oen), .io3_i(io3_w), .io3_o(io3_o), .io3_oen_o(io3_oen), .so_o(so_q),
		.so_oen_o(so_oen), .so_dout_i(so_d), .so_drive_i(so_dr), .quad_dout_i(qd),
		.quad_drive_i(qdr), .sck_rise_o(rise), .pause_o(pause), .dev_reset_o(dev_rst),
		.quad_mode_o(quad), .quad_din_o(qdin));

	// second copy without a dedicated reset pin, fed the same bus and pins
	fpp_pin_logic #(.HAS_DED_RST(1'b0)) i_fpp_pin_logic_b (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(), .hresp_o(), .hrdata_o(),
		.cs_n_i(cs_n), .sck_i(sck), .ded_rst_n_i(ded_lvl), .io2_i(io2_w), .io2_o(), .io2_oen_o(),
		.io3_i(io3_w), .io3_o(), .io3_oen_o(), .so_o(), .so_oen_o(), .so_dout_i(so_d),
		.so_drive_i(so_dr), .quad_dout_i(qd), .quad_drive_i(qdr), .sck_rise_o(), .pause_o(pause_b),
		.dev_reset_o(dev_rst_b), .quad_mode_o(), .quad_din_o());

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer; waits on hready, read data taken at the data phase edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, input logic [31:0] exp);
		@(posedge clk_sys_i);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys_i); while (hready !== 1'b1);
		if (!w) chk(hrdata, exp);
		chk(hresp, fpp_pkg::HRESP_OKAY);
	endtask

	task automatic pins(input logic w, input logic h, input logic d);
		@(posedge clk_sys_i);
		wp_lvl <= w;
		hold_lvl <= h;
		ded_lvl <= d;
		repeat (5) @(posedge clk_sys_i);
	endtask

	task automatic frame_rises(output int n);
		n0 = n_rise;
		repeat (40) @(posedge clk_sys_i);
		n = n_rise - n0;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#100us;
		errors++;
		end_sim;
	end

	initial begin
		int n;
		repeat (2) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		bus(fpp_pkg::ADDR_STATUS, 0, 0, 32'h0);
		bus(fpp_pkg::ADDR_FUNC, 0, 0, 32'h0);
		bus(fpp_pkg::ADDR_READP, 0, 0, 32'h0);
		bus(8'h10, 0, 0, 32'h0);
		bus(fpp_pkg::ADDR_PINS, 0, 0, 32'h8e);
		$display("test reset values done");
		bus(fpp_pkg::ADDR_STATUS, 1, 32'hbc, 0);
		bus(fpp_pkg::ADDR_STATUS, 0, 0, 32'hbc);
		bus(fpp_pkg::ADDR_STATUS, 1, 32'h00, 0);
		bus(fpp_pkg::ADDR_STATUS, 0, 0, 32'hbc);
		bus(fpp_pkg::ADDR_FUNC, 0, 0, 32'h0);
		pins(1, 1, 1);
		bus(fpp_pkg::ADDR_STATUS, 1, 32'h84, 0);
		bus(fpp_pkg::ADDR_STATUS, 0, 0, 32'h84);
		pins(0, 1, 1);
		$display("test status protection done");
		run <= 1'b1;
		frame_rises(n);
		chk(n > 0, 1);
		chk({so_oen, so_q}, 2'b01);
		pins(0, 0, 1);
		chk({pause, so_oen}, 2'b11);
		chk(pause_b, 1);
		frame_rises(n);
		chk(n, 0);
		pins(0, 1, 1);
		frame_rises(n);
		chk(n > 0, 1);
		$display("test pause done");
		pins(0, 1, 0);
		chk({dev_rst, so_oen}, 2'b11);
		chk(dev_rst_b, 0);
		pins(0, 1, 1);
		bus(fpp_pkg::ADDR_FUNC, 1, 32'h1, 0);
		pins(0, 1, 0);
		chk(dev_rst, 0);
		bus(fpp_pkg::ADDR_READP, 1, 32'h80, 0);
		pins(0, 0, 1);
		chk({dev_rst, pause}, 2'b10);
		chk({dev_rst_b, pause_b}, 2'b10);
		pins(0, 1, 1);
		bus(fpp_pkg::ADDR_FUNC, 1, 32'h0, 0);
		pins(0, 0, 1);
		chk({dev_rst, pause}, 2'b01);
		chk({dev_rst_b, pause_b}, 2'b10);
		pins(1, 1, 1);
		$display("test reset functions done");
		bus(fpp_pkg::ADDR_STATUS, 1, 32'hc0, 0);
		pins(0, 0, 1);
		chk({quad, pause, dev_rst, qdin}, 5'b10000);
		bus(fpp_pkg::ADDR_STATUS, 1, 32'h40, 0);
		bus(fpp_pkg::ADDR_STATUS, 0, 0, 32'h40);
		pins(1, 1, 1);
		chk(qdin, 2'b11);
		qdr <= 1'b1;
		qd <= 2'b10;
		pins(1, 1, 1);
		chk({io3_oen, io2_oen, io3_o, io2_o}, 4'b0010);
		chk(qdin, 2'b10);
		pins(1, 1, 0);
		chk({dev_rst, so_oen, io2_oen, io3_oen}, 4'b1111);
		pins(1, 1, 1);
		run <= 1'b0;
		$display("test quad mode done");
		end_sim;
	end
endmodule // tb_fpp_pin_logic

`default_nettype wire
